/* File: pkg/tccm_regs.svh */
// Register offsets, field positions, reset values and timing counts of the channel 3/4 mode block
// Operation
// - A filtered input changes only after N successive samples agree on the new level.
// - Channel 4 filter field is bits 15:12; codes 0000, 0001, 0010 sample at clock rate.
// - Codes 0100, 0101 sample at clock/2 (N 6, 8); 0110 samples at clock/4 (N 8).
// - Codes 1010, 1011, 1100 sample at clock/16 with N of 5, 6 and 8.
// - Codes 1101, 1110, 1111 sample at clock/32 (N 5, 6, 8); 1001 at clock/8, N 8.
// - Prescaler bits 11:10 capture every edge, or once per 2, 4 or 8 events.
// - Filter and prescaler act only while the channel selection field is nonzero.
// - Channel 4 select bits 9:8: output, input four, input three, internal trigger.
// - Channel 3 select bits 1:0: output, input three, input four, internal trigger.
// - Channel 3 filter bits 7:4 and prescaler bits 3:2 behave as channel 4's do.
// - Channel 3 output mode, buffer and fast enable apply only when channel is output.
// - Output and input fields share bit positions; the selection field picks the meaning.
`ifndef TCCM_REGS_SVH
`define TCCM_REGS_SVH

`define TCCM_ADDR_W 8
`define TCCM_MODE_OFS 8'h1C
`define TCCM_ENABLE_OFS 8'h20
`define TCCM_STATUS_OFS 8'h30

`define TCCM_MODE_RESET 16'h0000
`define TCCM_MODE_WMASK 16'hFFFF
`define TCCM_CH_STRIDE 8
`define TCCM_SEL_LSB 0
`define TCCM_PSC_LSB 2
`define TCCM_FILT_LSB 4
`define TCCM_OCFE_BIT 2
`define TCCM_OCBE_BIT 3
`define TCCM_OCM_LSB 4

`define TCCM_EN_RESET 4'h0
`define TCCM_CH3_EN_BIT 8
`define TCCM_CH3_POL_BIT 9
`define TCCM_CH4_EN_BIT 12
`define TCCM_CH4_POL_BIT 13

`define TCCM_ST_LEVEL_LSB 0
`define TCCM_ST_SELWARN_LSB 2
`define TCCM_ST_CH3_CNT_LSB 8
`define TCCM_ST_CH4_CNT_LSB 16

`define TCCM_RATE_CLK1 3'h0
`define TCCM_RATE_CLK2 3'h1
`define TCCM_RATE_CLK4 3'h2
`define TCCM_RATE_CLK8 3'h3
`define TCCM_RATE_CLK16 3'h4
`define TCCM_RATE_CLK32 3'h5
`define TCCM_LEN_NONE 4'h1

`endif

/* File: pkg/tccm_pkg.sv */
// Types shared by the channel 3/4 mode block
package tccm_pkg;

   typedef enum logic [1:0] {
      TCCM_SEL_OUTPUT  = 2'h0,
      TCCM_SEL_NATIVE  = 2'h1,
      TCCM_SEL_CROSS   = 2'h2,
      TCCM_SEL_TRIGGER = 2'h3
   } tccmSel_t;

   typedef struct packed {
      logic [3:0] filter;
      logic [1:0] prescale;
      logic [1:0] select;
   } tccmInCfg_t;

   typedef struct packed {
      logic [2:0] mode;
      logic bufferEn;
      logic fastEn;
   } tccmOutCfg_t;

   typedef struct packed {
      logic [2:0] rateShift;
      logic [3:0] length;
   } tccmFilt_t;

endpackage

/* File: verilog/tccm_input_cond.sv */
// One capture input: sampling divider, digital filter, edge detect and capture prescaler
`timescale 1ns/100ps
`include "tccm_regs.svh"
module tccm_input_cond import tccm_pkg::*; #(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic rawIn,
   input tccmInCfg_t cfg,
   input wire logic captureEnable,
   input wire logic invert,
   output logic filtLevel,
   output logic capturePulse,
   output logic [CNT_W-1:0] captureCount
);

   function automatic tccmFilt_t decodeFilter(input logic [3:0] code);
      tccmFilt_t f;
      f = '{rateShift: `TCCM_RATE_CLK1, length: `TCCM_LEN_NONE};
      case (code)
         4'h0: f = '{rateShift: `TCCM_RATE_CLK1, length: `TCCM_LEN_NONE};
         4'h1: f = '{rateShift: `TCCM_RATE_CLK1, length: 4'h2};
         4'h2: f = '{rateShift: `TCCM_RATE_CLK1, length: 4'h8};
         4'h3: f = '{rateShift: `TCCM_RATE_CLK1, length: 4'h8};
         4'h4: f = '{rateShift: `TCCM_RATE_CLK2, length: 4'h6};
         4'h5: f = '{rateShift: `TCCM_RATE_CLK2, length: 4'h8};
         4'h6: f = '{rateShift: `TCCM_RATE_CLK4, length: 4'h8};
         4'h7: f = '{rateShift: `TCCM_RATE_CLK4, length: 4'h6};
         4'h8: f = '{rateShift: `TCCM_RATE_CLK8, length: 4'h6};
         4'h9: f = '{rateShift: `TCCM_RATE_CLK8, length: 4'h8};
         4'hA: f = '{rateShift: `TCCM_RATE_CLK16, length: 4'h5};
         4'hB: f = '{rateShift: `TCCM_RATE_CLK16, length: 4'h6};
         4'hC: f = '{rateShift: `TCCM_RATE_CLK16, length: 4'h8};
         4'hD: f = '{rateShift: `TCCM_RATE_CLK32, length: 4'h5};
         4'hE: f = '{rateShift: `TCCM_RATE_CLK32, length: 4'h6};
         default: f = '{rateShift: `TCCM_RATE_CLK32, length: 4'h8};
      endcase
      return f;
   endfunction

   tccmFilt_t filt;
   logic isInput;
   logic [5:0] span;
   logic [4:0] rateMask;
   logic tick;
   logic [2:0] pscLimit;
   logic [4:0] divCnt_q, divCnt_d;
   logic [3:0] agree_q, agree_d;
   logic level_q, level_d;
   logic [2:0] psc_q, psc_d;
   logic pulse_q, pulse_d;
   logic [CNT_W-1:0] count_q, count_d;
   logic activeEdge;

   always_comb begin
      filt = decodeFilter(cfg.filter);
      isInput = (cfg.select != TCCM_SEL_OUTPUT);
      span = 6'h01 << filt.rateShift;
      rateMask = 5'(span - 6'h01);
      tick = ((divCnt_q & rateMask) == 5'h00);
      pscLimit = 3'((4'h1 << cfg.prescale) - 4'h1);
      divCnt_d = isInput ? divCnt_q + 5'h01 : 5'h00;
      agree_d = agree_q;
      level_d = level_q;
      if (!isInput) begin
         agree_d = 4'h0;
      end else if (tick) begin
         if (rawIn == level_q) begin
            agree_d = 4'h0;
         end else if (agree_q + 4'h1 >= filt.length) begin
            level_d = rawIn;
            agree_d = 4'h0;
         end else begin
            agree_d = agree_q + 4'h1;
         end
      end
      // Active edge is rising unless the channel polarity inverts it
      activeEdge = (level_d != level_q) && ((level_d ^ invert) == 1'b1);
      psc_d = psc_q;
      pulse_d = 1'b0;
      count_d = count_q;
      if (!isInput || !captureEnable) begin
         psc_d = 3'h0;
      end else if (activeEdge) begin
         if (psc_q >= pscLimit) begin
            psc_d = 3'h0;
            pulse_d = 1'b1;
            count_d = count_q + CNT_W'(1);
         end else begin
            psc_d = psc_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         divCnt_q <= 5'h00;
         agree_q <= 4'h0;
         level_q <= 1'b0;
         psc_q <= 3'h0;
         pulse_q <= 1'b0;
         count_q <= '0;
      end else begin
         divCnt_q <= divCnt_d;
         agree_q <= agree_d;
         level_q <= level_d;
         psc_q <= psc_d;
         pulse_q <= pulse_d;
         count_q <= count_d;
      end
   end

   assign filtLevel = level_q;
   assign capturePulse = pulse_q;
   assign captureCount = count_q;

endmodule

/* File: verilog/tccm_top.sv */
// Channel 3/4 capture/compare mode register with input routing, filtering and prescaling
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "tccm_regs.svh"
module tccm_top import tccm_pkg::*; #(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`TCCM_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timerInputThree,
   input wire logic timerInputFour,
   input wire logic internalTriggerInput,
   output logic [1:0] channelIsInput,
   output logic [1:0] filteredLevel,
   output logic [1:0] captureEvent,
   output tccmOutCfg_t ch3OutCfg,
   output tccmOutCfg_t ch4OutCfg
);

   logic [15:0] mode_q, mode_d;
   logic [3:0] enable_q, enable_d;
   logic [1:0] selWarn_q, selWarn_d;
   logic ack_q, ack_d;
   logic [31:0] rdData_q, rdData_d;
   tccmOutCfg_t ch3Out_q, ch3Out_d;
   tccmOutCfg_t ch4Out_q, ch4Out_d;
   logic [1:0] isInput_q, isInput_d;

   logic access;
   logic wrMode;
   logic wrEnable;
   logic wrStatus;
   logic [15:0] laneMask;
   logic [15:0] modeWrite;
   logic [1:0] chEnable;
   logic [1:0] chInvert;
   logic [1:0] routed;
   logic [1:0] selChange;
   logic [CNT_W-1:0] capCount [2];
   tccmInCfg_t inCfg [2];
   logic [31:0] statusWord;
   logic [31:0] enableWord;

   // Bus decode: one access per request, answered one cycle later
   always_comb begin
      access = wb_cyc_i && wb_stb_i && !ack_q;
      wrMode = access && wb_we_i && (wb_adr_i == `TCCM_MODE_OFS);
      wrEnable = access && wb_we_i && (wb_adr_i == `TCCM_ENABLE_OFS);
      wrStatus = access && wb_we_i && (wb_adr_i == `TCCM_STATUS_OFS);
      laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      modeWrite = ((mode_q & ~laneMask) | (wb_dat_i[15:0] & laneMask)) & `TCCM_MODE_WMASK;
   end

   assign chEnable = {enable_q[2], enable_q[0]};
   assign chInvert = {enable_q[3], enable_q[1]};

   // Per-channel source routing and input conditioning
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : gChan
         logic native;
         logic crossIn;
         assign native = (ch == 0) ? timerInputThree : timerInputFour;
         assign crossIn = (ch == 0) ? timerInputFour : timerInputThree;
         assign inCfg[ch] = tccmInCfg_t'(mode_q[ch*`TCCM_CH_STRIDE +: 8]);

         always_comb begin
            case (tccmSel_t'(inCfg[ch].select))
               TCCM_SEL_NATIVE: routed[ch] = native;
               TCCM_SEL_CROSS: routed[ch] = crossIn;
               // Trigger choice itself lives in slave mode control, outside this block
               TCCM_SEL_TRIGGER: routed[ch] = internalTriggerInput;
               default: routed[ch] = 1'b0;
            endcase
         end

         // A selection change while the channel is on is flagged, not blocked
         assign selChange[ch] = wrMode && chEnable[ch] &&
            (modeWrite[ch*`TCCM_CH_STRIDE +: 2] != mode_q[ch*`TCCM_CH_STRIDE +: 2]);

         tccm_input_cond #(
            .CNT_W(CNT_W)
         ) uCond (
            .clk(clk),
            .resetn(resetn),
            .rawIn(routed[ch]),
            .cfg(inCfg[ch]),
            .captureEnable(chEnable[ch]),
            .invert(chInvert[ch]),
            .filtLevel(filteredLevel[ch]),
            .capturePulse(captureEvent[ch]),
            .captureCount(capCount[ch])
         );
      end
   endgenerate

   // Register file next state
   always_comb begin
      mode_d = mode_q;
      enable_d = enable_q;
      selWarn_d = selWarn_q;
      if (wrMode) begin
         mode_d = modeWrite;
      end
      if (wrEnable && wb_sel_i[1]) begin
         enable_d = {wb_dat_i[`TCCM_CH4_POL_BIT], wb_dat_i[`TCCM_CH4_EN_BIT],
                     wb_dat_i[`TCCM_CH3_POL_BIT], wb_dat_i[`TCCM_CH3_EN_BIT]};
      end
      if (wrStatus && wb_sel_i[0]) begin
         selWarn_d = selWarn_q & ~wb_dat_i[`TCCM_ST_SELWARN_LSB +: 2];
      end
      // Setting wins over a clear in the same cycle
      selWarn_d = selWarn_d | selChange;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_q <= `TCCM_MODE_RESET;
         enable_q <= `TCCM_EN_RESET;
         selWarn_q <= 2'h0;
      end else begin
         mode_q <= mode_d;
         enable_q <= enable_d;
         selWarn_q <= selWarn_d;
      end
   end

   // Output compare fields reach the compare logic only for an output channel
   always_comb begin
      ch3Out_d = '0;
      ch4Out_d = '0;
      isInput_d[0] = (mode_q[`TCCM_SEL_LSB +: 2] != TCCM_SEL_OUTPUT);
      isInput_d[1] = (mode_q[`TCCM_CH_STRIDE + `TCCM_SEL_LSB +: 2] != TCCM_SEL_OUTPUT);
      if (!isInput_d[0]) begin
         ch3Out_d.mode = mode_q[`TCCM_OCM_LSB +: 3];
         ch3Out_d.bufferEn = mode_q[`TCCM_OCBE_BIT];
         ch3Out_d.fastEn = mode_q[`TCCM_OCFE_BIT];
      end
      if (!isInput_d[1]) begin
         ch4Out_d.mode = mode_q[`TCCM_CH_STRIDE + `TCCM_OCM_LSB +: 3];
         ch4Out_d.bufferEn = mode_q[`TCCM_CH_STRIDE + `TCCM_OCBE_BIT];
         ch4Out_d.fastEn = mode_q[`TCCM_CH_STRIDE + `TCCM_OCFE_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ch3Out_q <= '0;
         ch4Out_q <= '0;
         isInput_q <= 2'h0;
      end else begin
         ch3Out_q <= ch3Out_d;
         ch4Out_q <= ch4Out_d;
         isInput_q <= isInput_d;
      end
   end

   assign ch3OutCfg = ch3Out_q;
   assign ch4OutCfg = ch4Out_q;
   assign channelIsInput = isInput_q;

   // Read data and acknowledge
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[`TCCM_ST_LEVEL_LSB +: 2] = filteredLevel;
      statusWord[`TCCM_ST_SELWARN_LSB +: 2] = selWarn_q;
      statusWord[`TCCM_ST_CH3_CNT_LSB +: 8] = 8'(capCount[0]);
      statusWord[`TCCM_ST_CH4_CNT_LSB +: 8] = 8'(capCount[1]);
      enableWord = 32'h0000_0000;
      enableWord[`TCCM_CH3_EN_BIT] = enable_q[0];
      enableWord[`TCCM_CH3_POL_BIT] = enable_q[1];
      enableWord[`TCCM_CH4_EN_BIT] = enable_q[2];
      enableWord[`TCCM_CH4_POL_BIT] = enable_q[3];
      ack_d = access;
      rdData_d = rdData_q;
      if (access && !wb_we_i) begin
         case (wb_adr_i)
            `TCCM_MODE_OFS: rdData_d = {16'h0000, mode_q};
            `TCCM_ENABLE_OFS: rdData_d = enableWord;
            `TCCM_STATUS_OFS: rdData_d = statusWord;
            default: rdData_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         rdData_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         rdData_q <= rdData_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdData_q;

endmodule

/* File: testbench/tccm_top_chk.sv */
// Port-level assertions for the channel 3/4 mode block
`timescale 1ns/100ps
module tccm_top_chk import tccm_pkg::*; #(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] channelIsInput,
   input wire logic [1:0] filteredLevel,
   input wire logic [1:0] captureEvent,
   input tccmOutCfg_t ch3OutCfg,
   input tccmOutCfg_t ch4OutCfg
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stayed high");
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_ch3_out_gated: assert property (channelIsInput[0] && $past(channelIsInput[0]) |->
      ch3OutCfg == 5'h00) else $error("ch3 output fields live while input");
   a_ch4_out_gated: assert property (channelIsInput[1] && $past(channelIsInput[1]) |->
      ch4OutCfg == 5'h00) else $error("ch4 output fields live while input");
   // The flag lags the mode register by one cycle, so either cycle may allow a capture
   a_cap_input_only: assert property (
      (captureEvent & ~(channelIsInput | $past(channelIsInput))) == 2'h0)
      else $error("capture on an output channel");
   a_cap_one_cycle: assert property (captureEvent[0] |=> !captureEvent[0])
      else $error("capture pulse too long");
   a_cap_on_change: assert property (|captureEvent |->
      ((filteredLevel ^ $past(filteredLevel)) & captureEvent) == captureEvent)
      else $error("capture without filtered level change");
   a_filt_frozen: assert property (!channelIsInput[1] && !$past(channelIsInput[1]) |->
      $stable(filteredLevel[1])) else $error("filter moved on an output channel");
endmodule

bind tccm_top tccm_top_chk #(.CNT_W(CNT_W)) i_chk (.clk(clk), .resetn(resetn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .channelIsInput(channelIsInput), .filteredLevel(filteredLevel),
   .captureEvent(captureEvent), .ch3OutCfg(ch3OutCfg), .ch4OutCfg(ch4OutCfg));

/* File: testbench/tccm_pin_model.sv */
// Model of the timer input pins and the internal trigger source
`timescale 1ns/100ps
module tccm_pin_model (
   input wire logic clk,
   input wire logic [2:0] want,
   output logic pinThree,
   output logic pinFour,
   output logic trig
);
   initial begin
      pinThree = 1'b0;
      pinFour = 1'b0;
      trig = 1'b0;
   end
   // Levels move only after an edge, as a synchronous source would
   always @(posedge clk) begin
      pinThree <= want[0];
      pinFour <= want[1];
      trig <= want[2];
   end
endmodule

/* File: testbench/tccm_top_tb.sv */
// Self-checking bench for the channel 3/4 mode block
`timescale 1ns/100ps
module tccm_top_tb import tccm_pkg::*;;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDat = 32'h0;
   logic [31:0] datO, rd;
   logic [2:0] want = 3'h0;
   logic t3, t4, trg, ack;
   logic [1:0] isIn, filt, cap;
   tccmOutCfg_t ch3Out, ch4Out;
   int errorCnt = 0;
   int compares = 0;
   int capN [2] = '{0, 0};
   int sh [16] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};
   int nn [16] = '{1, 2, 8, 8, 6, 8, 8, 6, 6, 8, 5, 6, 8, 5, 6, 8};
   int m4 [4] = '{0, 1, 0, 2};

   always #20 clk = ~clk;
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (cap[i] === 1'b1) capN[i]++;
      end
   end

   tccm_pin_model i_pins (.clk(clk), .want(want), .pinThree(t3), .pinFour(t4), .trig(trg));
   tccm_top i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(datO),
      .wb_ack_o(ack), .timerInputThree(t3), .timerInputFour(t4), .internalTriggerInput(trg),
      .channelIsInput(isIn), .filteredLevel(filt), .captureEvent(cap), .ch3OutCfg(ch3Out),
      .ch4OutCfg(ch4Out));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkRange(input string nm, input int lo, input int hi, input int g);
      compares++;
      if (g < lo || g > hi) begin
         errorCnt++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic endOfTest;
      if (errorCnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Entered just after a rising edge; request held until ack is sampled
   task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= s;
      wbDat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) chk("ack", 32'h1, 32'h0);
      rd = datO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0, 4'hF);
      chk(nm, e, rd);
   endtask

   task automatic waitFilt(input int ch, input logic v, output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (filt[ch] !== v && n < 400);
      @(posedge clk);
   endtask

   task automatic pulses(input int n);
      repeat (n) begin
         want <= 3'h3;
         repeat (4) @(posedge clk);
         want <= 3'h0;
         repeat (4) @(posedge clk);
      end
   endtask

   initial begin
      #(40 * 60000);
      errorCnt++;
      endOfTest();
   end

   initial begin
      int ch, n, b0, b1;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rdChk("mode reset", 8'h1C, 32'h0);
      rdChk("enable reset", 8'h20, 32'h0);
      xfer(8'h1C, 1'b1, 32'hFFFFFFFF, 4'h1);
      rdChk("mode low byte", 8'h1C, 32'h000000FF);
      xfer(8'h1C, 1'b1, 32'hFFFFFFFF, 4'hF);
      rdChk("mode", 8'h1C, 32'h0000FFFF);
      xfer(8'h20, 1'b1, 32'hFFFFFFFF, 4'hF);
      rdChk("enable", 8'h20, 32'h00003300);
      xfer(8'h04, 1'b1, 32'hFFFFFFFF, 4'hF);
      rdChk("unmapped", 8'h04, 32'h0);
      chk("input flags", 32'h3, {30'h0, isIn});
      chk("ch3 out cfg", 32'h0, {27'h0, ch3Out});
      xfer(8'h20, 1'b1, 32'h0, 4'hF);
      xfer(8'h1C, 1'b1, 32'h00007C7C, 4'hF);
      @(posedge clk);
      chk("ch3 out cfg", 32'h1F, {27'h0, ch3Out});
      chk("ch4 out cfg", 32'h1F, {27'h0, ch4Out});
      // Even codes on channel 3, odd codes on channel 4
      for (int c = 0; c < 16; c++) begin
         ch = c % 2;
         want <= 3'h0;
         xfer(8'h1C, 1'b1, 32'({c[3:0], 4'h1}) << (8 * ch), 4'hF);
         waitFilt(ch, 1'b0, n);
         want[ch] <= 1'b1;
         waitFilt(ch, 1'b1, n);
         chkRange("filter delay", (nn[c] - 1) * (1 << sh[c]) + 3, nn[c] * (1 << sh[c]) + 2,
            n);
      end
      for (int s = 1; s < 4; s++) begin
         xfer(8'h1C, 1'b1, 32'(s * 257), 4'hF);
         for (int k = 0; k < 3; k++) begin
            want <= 3'(1 << k);
            repeat (6) @(posedge clk);
            chk("route", {30'h0, k == m4[s], k == s - 1}, {30'h0, filt});
         end
      end
      xfer(8'h1C, 1'b1, 32'h0, 4'hF);
      xfer(8'h20, 1'b1, 32'h00001100, 4'hF);
      b0 = capN[0] + capN[1];
      pulses(2);
      chk("frozen level", 32'h3, {30'h0, filt});
      chk("output captures", b0, capN[0] + capN[1]);
      for (int p = 0; p < 4; p++) begin
         xfer(8'h20, 1'b1, 32'h0, 4'hF);
         xfer(8'h1C, 1'b1, 32'h0101 | (p * 32'h0404), 4'hF);
         xfer(8'h20, 1'b1, 32'h00001100, 4'hF);
         b0 = capN[0];
         b1 = capN[1];
         pulses(8);
         chk("ch3 captures", 8 >> p, capN[0] - b0);
         chk("ch4 captures", 8 >> p, capN[1] - b1);
      end
      // Inverted polarity: only falling edges of the filtered level capture
      xfer(8'h20, 1'b1, 32'h0, 4'hF);
      xfer(8'h1C, 1'b1, 32'h00000101, 4'hF);
      xfer(8'h20, 1'b1, 32'h00003300, 4'hF);
      b0 = capN[0];
      b1 = capN[1];
      pulses(2);
      chk("ch3 falling captures", 2, capN[0] - b0);
      chk("ch4 falling captures", 2, capN[1] - b1);
      rdChk("status counts", 8'h30, 32'h00111100);
      // Deliberate select change while enabled, to see the warning raised
      xfer(8'h1C, 1'b1, 32'h00000202, 4'hF);
      rdChk("status warn", 8'h30, 32'h0011110C);
      xfer(8'h30, 1'b1, 32'h0000000C, 4'h1);
      rdChk("status cleared", 8'h30, 32'h00111100);
      endOfTest();
   end
endmodule
